// [rtl/vco_autocal_fsm.sv]
`timescale 1ns/1ps
// Behaviour
// R1 - Autocal on: each frequency change starts calibration
// R2 - Same-value rewrite reruns calibration
// R3 - Window is R times 2^n reference periods
// R4 - Window codes 0-7 give exponents 0-3, 5-8
// R5 - Ratio is integer plus fraction over 2^24
// R6 - Expected count is floor(ratio times 2^n)
// R7 - Machine clock is reference divided by 1, 4, 16 or 32
// R8 - Host keeps machine clock at most 50 MHz
// R9 - Machine clock paces the VCO serial link
// R10 - Worst case: six measurements, seven 20-tick sends
// R11 - Wait k times 128 machine cycles before measuring
// R12 - Divider loads only after the final switch value
// R13 - Chosen switches readable in 8 bits after calibration
// R14 - Autocal off: forwarding writes go to the VCO at once
// R15 - A forward takes 16 link clocks
// R16 - Autocal off: host writes switches first, then divider
// R17 - Fraction write calibrates then loads, or loads at once
// R18 - Fractional mode: host writes integer only when it changes
// R19 - Host forwards only for manual control or divider
// R20 - Every fractional-mode change includes a fractional write
// R21 - Fast hops: host replays stored calibrated switches
// R22 - Host picks a resolution finer than 800 kHz
// R23 - Word: target id bits 2:0, index bits 6:3, payload 15:7
// R24 - Host zeroes forwarding bits 6:0 before calibrating
// R25 - Integer-mode integer write calibrates then loads, or loads at once
// R26 - Switch bits searched MSB first, count versus expected
module vco_autocal_fsm
    import vco_cal_pkg::*;
(
    // Clock and reset
    input  wire logic                           sys_clk,
    input  wire logic                           reset,
    // Reference and VCO edge pulses
    input  wire logic                           refEdge,
    input  wire logic                           vcoEdge,
    input  wire logic [RDIV_BITS-1:0]           refDivRatio,
    // Configuration
    input  wire vco_cal_pkg::calCfg_t           cfg,
    // Host writes
    input  wire vco_cal_pkg::hostWrite_t        hostWr,
    // Divider outputs
    output logic [INT_BITS-1:0]                 prescalerInt,
    output logic [FRAC_BITS-1:0]                modulatorFrac,
    output logic                                dividerLoad,
    // Status
    output logic [7:0]                          switchReadback,
    output logic                                calBusy,
    // Internal VCO serial link
    output vco_cal_pkg::linkPins_t              internal_vco_serial_link
);
    import vco_cal_pkg::*;

    typedef enum logic [2:0] {
        PH_IDLE,
        PH_FORWARD,
        PH_SEND,
        PH_WAIT,
        PH_MEAS,
        PH_LOAD
    } phase_t;

    typedef struct packed {
        phase_t               phase;
        logic [4:0]           tickCnt;
        logic [SWITCH_BITS-1:0] swVal;
        logic [2:0]           bitIdx;
        logic                 firstSend;
        logic                 decided;
        logic                 commit;
        logic                 again;
        logic [8:0]           waitLeft;
        logic [WORD_BITS-1:0] fwdReg;
        logic [INT_BITS-1:0]  pendInt;
        logic [FRAC_BITS-1:0] pendFrac;
        logic [INT_BITS-1:0]  prescalerInt;
        logic [FRAC_BITS-1:0] modulatorFrac;
        logic                 dividerLoad;
        logic [7:0]           readback;
        logic                 linkStart;
        logic [WORD_BITS-1:0] linkWord;
        logic [4:0]           linkCycles;
        logic                 measStart;
    } calState_t;

    calState_t st_reg;
    calState_t st_next;

    logic                   tick;
    logic [4:0]             tickLimit;
    logic                   linkBusy;
    logic                   linkDone;
    logic                   measDone;
    logic [COUNT_BITS-1:0]  measCount;
    logic [3:0]             winExp;
    logic [WINDOW_BITS-1:0] window;
    logic [50:0]            scaled;
    logic [COUNT_BITS-1:0]  expected;
    logic                   calTrigger;
    logic                   directLoad;
    logic                   tooFast;

    // ------------------------------
    // Machine clock tick and measurement targets
    // ------------------------------

    // Divided reference as a tick; host keeps it within 50 MHz [R8]
    assign tickLimit = 5'((6'h01 << clkExp(cfg.clkSel)) - 6'h01); // [R7]
    assign tick      = refEdge && (st_reg.tickCnt >= tickLimit); // [R7]

    // Window of R times 2^n reference periods [R3] [R4]
    assign winExp = measExp(cfg.measSel); // [R4]
    assign window = WINDOW_BITS'({8'h00, refDivRatio} << winExp); // [R3]

    // Ratio with 24 fraction bits, scaled, then floored [R5] [R6]
    assign scaled   = {8'h00, st_reg.pendInt, st_reg.pendFrac} << winExp;
    assign expected = scaled[50:24]; // [R5] [R6]

    // Count above target: VCO fast, add capacitance
    assign tooFast = measCount > expected; // [R26]

    // Which write starts a calibration, by mode [R17] [R25]
    assign calTrigger = cfg.fracMode ? hostWr.fracWrite
                                     : hostWr.intWrite;
    // Autocal off: written divider goes straight through [R17] [R25]
    assign directLoad = cfg.autoCalOff && calTrigger;

    // ------------------------------
    // Next-state logic
    // ------------------------------
    always_comb begin
        st_next             = st_reg;
        st_next.linkStart   = 1'b0;
        st_next.measStart   = 1'b0;
        st_next.dividerLoad = 1'b0;

        // Tick divider wraps on each machine tick
        if (refEdge) begin
            st_next.tickCnt = tick ? 5'h00 : st_reg.tickCnt + 5'h01;
        end

        // Host register captures
        if (hostWr.intWrite) begin
            st_next.pendInt = hostWr.intValue;
        end
        if (hostWr.fracWrite) begin
            st_next.pendFrac = hostWr.fracValue;
        end
        if (hostWr.fwdWrite) begin
            st_next.fwdReg = hostWr.fwdValue;
        end

        // Direct load with no VCO adjustment [R17] [R25]
        if (directLoad) begin
            st_next.prescalerInt  = hostWr.intWrite ? hostWr.intValue
                                                    : st_reg.prescalerInt;
            st_next.modulatorFrac = hostWr.fracWrite ? hostWr.fracValue
                                                     : st_reg.modulatorFrac;
            st_next.dividerLoad   = 1'b1;
        end else if (calTrigger && st_reg.phase != PH_IDLE) begin
            // Rerun after this pass, even at same value [R2]
            st_next.again = 1'b1;
        end

        case (st_reg.phase)
            PH_IDLE: begin
                if (hostWr.fwdWrite) begin
                    // Forward now, 16 link cycles [R14] [R15]
                    st_next.linkStart  = 1'b1;
                    st_next.linkWord   = hostWr.fwdValue;
                    st_next.linkCycles = FWD_XFER_TICKS; // [R15]
                    st_next.phase      = PH_FORWARD;
                    st_next.again      = calTrigger && !cfg.autoCalOff;
                end else if (calTrigger && !cfg.autoCalOff) begin
                    st_next.again = 1'b1; // [R1]
                    st_next.phase = PH_LOAD;
                end
            end
            PH_FORWARD: begin
                if (linkDone) begin
                    st_next.phase = st_reg.again ? PH_LOAD : PH_IDLE;
                end
            end
            PH_SEND: begin
                if (linkDone) begin
                    if (st_reg.commit) begin
                        st_next.phase = PH_LOAD; // [R12]
                    end else if (st_reg.firstSend) begin
                        st_next.firstSend = 1'b0;
                        st_next.waitLeft  = 9'({7'h00, cfg.waitK}
                                               * WAIT_UNIT_TICKS); // [R11]
                        st_next.phase     = PH_WAIT;
                    end else begin
                        st_next.measStart = 1'b1;
                        st_next.phase     = PH_MEAS;
                    end
                end
            end
            PH_WAIT: begin
                if (st_reg.waitLeft == 9'h000) begin
                    st_next.measStart = 1'b1;
                    st_next.phase     = PH_MEAS;
                end else if (tick) begin
                    st_next.waitLeft = st_reg.waitLeft - 9'h001; // [R11]
                end
            end
            PH_MEAS: begin
                if (measDone) begin
                    st_next.linkStart = 1'b1;
                    st_next.phase     = PH_SEND;
                    if (st_reg.decided) begin
                        // Check pass done: resend final word [R10]
                        st_next.commit = 1'b1;
                    end else begin
                        st_next.swVal[st_reg.bitIdx] = tooFast; // [R26]
                        if (st_reg.bitIdx == 3'h0) begin
                            st_next.decided = 1'b1;
                        end else begin
                            st_next.bitIdx = st_reg.bitIdx - 3'h1;
                            st_next.swVal[st_reg.bitIdx - 3'h1] = 1'b1;
                        end
                    end
                    // Switch field replaced, id and index kept [R23]
                    st_next.linkWord = {st_reg.fwdReg[WORD_BITS-1:
                                                      READBACK_TOP_LSB],
                                        st_next.swVal,
                                        st_reg.fwdReg[SWITCH_LSB-1:0]};
                end
            end
            PH_LOAD: begin
                if (st_reg.commit) begin
                    // Final switch set: now load divider [R12] [R13]
                    st_next.prescalerInt  = st_reg.pendInt;
                    st_next.modulatorFrac = st_reg.pendFrac;
                    st_next.dividerLoad   = 1'b1;
                    st_next.readback      = {st_reg.fwdReg[15:13],
                                             st_reg.swVal}; // [R13]
                    st_next.commit        = 1'b0;
                end
                if (st_reg.again || !st_reg.commit) begin
                    if (linkBusy) begin
                        st_next.phase = PH_LOAD;
                    end else begin
                        // Start a pass at the bank midpoint [R1] [R26]
                        st_next.again      = 1'b0;
                        st_next.commit     = 1'b0;
                        st_next.swVal      = SWITCH_MIDPOINT;
                        st_next.bitIdx     = SWITCH_TOP_BIT;
                        st_next.firstSend  = 1'b1;
                        st_next.decided    = 1'b0;
                        st_next.linkStart  = 1'b1;
                        st_next.linkCycles = CAL_XFER_TICKS; // [R10]
                        st_next.linkWord   = {st_reg.fwdReg[15:13],
                                              SWITCH_MIDPOINT,
                                              st_reg.fwdReg[7:0]};
                        st_next.phase      = PH_SEND;
                    end
                end else begin
                    st_next.phase = PH_IDLE;
                end
            end
            default: begin
                st_next.phase = PH_IDLE;
            end
        endcase
    end

    // ------------------------------
    // State register
    // ------------------------------
    always_ff @(posedge sys_clk) begin
        if (reset) begin
            st_reg          <= '0;
            st_reg.phase    <= PH_IDLE;
            st_reg.fwdReg   <= FWD_RESET;
            st_reg.readback <= READBACK_RESET;
        end else begin
            st_reg <= st_next;
        end
    end

    // ------------------------------
    // Link shifter and edge counter
    // ------------------------------

    // Link runs on the machine tick [R9]
    vco_link_tx u_link (
        .sys_clk (sys_clk),
        .reset   (reset),
        .tick    (tick),
        .start   (st_reg.linkStart),
        .word    (st_reg.linkWord),
        .cycles  (st_reg.linkCycles),
        .busy    (linkBusy),
        .done    (linkDone),
        .pins    (internal_vco_serial_link)
    );

    vco_meas_counter u_meas (
        .sys_clk (sys_clk),
        .reset   (reset),
        .start   (st_reg.measStart),
        .window  (window),
        .refEdge (refEdge),
        .vcoEdge (vcoEdge),
        .count   (measCount),
        .done    (measDone)
    );

    // ------------------------------
    // Outputs
    // ------------------------------
    assign prescalerInt   = st_reg.prescalerInt;
    assign modulatorFrac  = st_reg.modulatorFrac;
    assign dividerLoad    = st_reg.dividerLoad;
    assign switchReadback = st_reg.readback;
    assign calBusy        = st_reg.phase != PH_IDLE;

endmodule : vco_autocal_fsm

// [rtl/vco_cal_pkg.sv]
package vco_cal_pkg;

    // ------------------------------
    // Widths
    // ------------------------------
    localparam int INT_BITS    = 19;
    localparam int FRAC_BITS   = 24;
    localparam int RDIV_BITS   = 14;
    localparam int WINDOW_BITS = 22;
    localparam int COUNT_BITS  = 27;
    localparam int WORD_BITS   = 16;
    localparam int SWITCH_BITS = 5;

    // ------------------------------
    // Forwarded word layout
    // ------------------------------
    localparam int TARGET_ID_LSB    = 0;
    localparam int REG_INDEX_LSB    = 3;
    localparam int PAYLOAD_LSB      = 7;
    localparam int SWITCH_LSB       = 8;
    localparam int READBACK_TOP_LSB = 13;

    // ------------------------------
    // Cycle counts and reset values
    // ------------------------------
    localparam logic [8:0]  WAIT_UNIT_TICKS = 9'h080;
    localparam logic [4:0]  CAL_XFER_TICKS  = 5'h14;
    localparam logic [4:0]  FWD_XFER_TICKS  = 5'h10;
    localparam logic [2:0]  SWITCH_TOP_BIT  = 3'h4;
    localparam logic [4:0]  SWITCH_MIDPOINT = 5'h10;
    localparam logic [15:0] FWD_RESET       = 16'h0000;
    localparam logic [7:0]  READBACK_RESET  = 8'h00;

    // ------------------------------
    // Grouped signals
    // ------------------------------
    typedef struct packed {
        logic       autoCalOff;
        logic       fracMode;
        logic [1:0] clkSel;
        logic [1:0] waitK;
        logic [2:0] measSel;
    } calCfg_t;

    typedef struct packed {
        logic                 intWrite;
        logic                 fracWrite;
        logic                 fwdWrite;
        logic [INT_BITS-1:0]  intValue;
        logic [FRAC_BITS-1:0] fracValue;
        logic [WORD_BITS-1:0] fwdValue;
    } hostWrite_t;

    typedef struct packed {
        logic serClk;
        logic serData;
        logic serEnable;
    } linkPins_t;

    // Window exponent: codes 4..7 skip exponent 4
    function automatic logic [3:0] measExp(input logic [2:0] sel);
        measExp = sel[2] ? {1'b0, sel} + 4'h1 : {1'b0, sel};
    endfunction : measExp

    // Machine clock exponent: 0, 2, 4 or 5
    function automatic logic [2:0] clkExp(input logic [1:0] sel);
        case (sel)
            2'h0:    clkExp = 3'h0;
            2'h1:    clkExp = 3'h2;
            2'h2:    clkExp = 3'h4;
            default: clkExp = 3'h5;
        endcase
    endfunction : clkExp

endpackage : vco_cal_pkg

// [rtl/vco_link_tx.sv]
`timescale 1ns/1ps
module vco_link_tx
    import vco_cal_pkg::*;
(
    // Clock and reset
    input  wire logic                  sys_clk,
    input  wire logic                  reset,
    // Machine clock tick
    input  wire logic                  tick,
    // Request
    input  wire logic                  start,
    input  wire logic [WORD_BITS-1:0]  word,
    input  wire logic [4:0]            cycles,
    // Status
    output logic                       busy,
    output logic                       done,
    // Link pins
    output vco_cal_pkg::linkPins_t     pins
);
    import vco_cal_pkg::*;

    typedef struct packed {
        logic                 active;
        logic [WORD_BITS-1:0] shift;
        logic [4:0]           left;
        logic                 done;
        linkPins_t            pins;
    } linkState_t;

    linkState_t st_reg;
    linkState_t st_next;

    // ------------------------------
    // Shifter, MSB first, one bit per machine tick
    // ------------------------------
    always_comb begin
        st_next             = st_reg;
        st_next.done        = 1'b0;
        st_next.pins.serClk = 1'b0;
        if (!st_reg.active && start) begin
            st_next.active = 1'b1;
            st_next.shift  = word;
            st_next.left   = cycles;
        end else if (st_reg.active && tick) begin
            st_next.pins.serClk  = 1'b1;
            st_next.pins.serData = st_reg.shift[WORD_BITS-1];
            st_next.shift        = {st_reg.shift[WORD_BITS-2:0], 1'b0};
            st_next.left         = st_reg.left - 5'h01;
            // Trailing ticks shift zeros: gap time for the receiver
            if (st_reg.left == 5'h01) begin
                st_next.active = 1'b0;
                st_next.done   = 1'b1;
            end
        end
        // Enable covers the last clock pulse as well
        st_next.pins.serEnable = st_next.active || st_next.pins.serClk;
    end

    always_ff @(posedge sys_clk) begin
        if (reset) begin
            st_reg <= '0;
        end else begin
            st_reg <= st_next;
        end
    end

    assign busy = st_reg.active;
    assign done = st_reg.done;
    assign pins = st_reg.pins;

endmodule : vco_link_tx

// [rtl/vco_meas_counter.sv]
`timescale 1ns/1ps
module vco_meas_counter
    import vco_cal_pkg::*;
(
    // Clock and reset
    input  wire logic                   sys_clk,
    input  wire logic                   reset,
    // Control
    input  wire logic                   start,
    input  wire logic [WINDOW_BITS-1:0] window,
    // Edges
    input  wire logic                   refEdge,
    input  wire logic                   vcoEdge,
    // Result
    output logic [COUNT_BITS-1:0]       count,
    output logic                        done
);
    import vco_cal_pkg::*;

    typedef struct packed {
        logic                   active;
        logic [WINDOW_BITS-1:0] left;
        logic [COUNT_BITS-1:0]  count;
        logic                   done;
    } measState_t;

    measState_t st_reg;
    measState_t st_next;

    // ------------------------------
    // Count VCO edges across a window of reference periods
    // ------------------------------
    always_comb begin
        st_next      = st_reg;
        st_next.done = 1'b0;
        if (start) begin
            st_next.active = 1'b1;
            st_next.left   = window;
            st_next.count  = '0;
        end else if (st_reg.active) begin
            if (vcoEdge) begin
                st_next.count = st_reg.count + 27'h0000001;
            end
            if (refEdge) begin
                st_next.left = st_reg.left - 22'h000001;
                if (st_reg.left <= 22'h000001) begin
                    st_next.active = 1'b0;
                    st_next.done   = 1'b1;
                end
            end
        end
    end

    always_ff @(posedge sys_clk) begin
        if (reset) begin
            st_reg <= '0;
        end else begin
            st_reg <= st_next;
        end
    end

    assign count = st_reg.count;
    assign done  = st_reg.done;

endmodule : vco_meas_counter

// [verif/vco_autocal_checker.sv]
`timescale 1ns/1ps
module vco_autocal_checker
    import vco_cal_pkg::*;
(
    // Clock and reset
    input  wire logic                   sys_clk,
    input  wire logic                   reset,
    // Watched ports
    input  wire vco_cal_pkg::calCfg_t   cfg,
    input  wire vco_cal_pkg::hostWrite_t hostWr,
    input  wire logic [INT_BITS-1:0]    prescalerInt,
    input  wire logic [FRAC_BITS-1:0]   modulatorFrac,
    input  wire logic                   dividerLoad,
    input  wire logic                   calBusy,
    input  wire vco_cal_pkg::linkPins_t internal_vco_serial_link
);
    // ----------------------------------------
    // Clock count of the current link frame
    // ----------------------------------------
    logic       en;
    logic [4:0] bits;
    assign en = internal_vco_serial_link.serEnable;
    always_ff @(posedge sys_clk) begin
        bits <= (reset || !en) ? 5'h00
                : bits + 5'(internal_vco_serial_link.serClk);
    end
    default clocking @(posedge sys_clk); endclocking
    default disable iff (reset);
    a_fwd_start: assert property (
        cfg.autoCalOff && hostWr.fwdWrite && !calBusy |=> calBusy ##1 en)
        else $error("Late forward");
    a_off_frac: assert property (
        cfg.autoCalOff && cfg.fracMode && hostWr.fracWrite && !calBusy
        |=> dividerLoad && modulatorFrac == $past(hostWr.fracValue))
        else $error("Late fraction");
    a_off_int: assert property (
        cfg.autoCalOff && !cfg.fracMode && hostWr.intWrite && !calBusy
        |=> dividerLoad && prescalerInt == $past(hostWr.intValue))
        else $error("Late integer");
    a_cal_start: assert property (
        !cfg.autoCalOff && !calBusy
        && (cfg.fracMode ? hostWr.fracWrite : hostWr.intWrite)
        |=> calBusy && !dividerLoad) else $error("No calibration");
    a_load_quiet: assert property (
        dividerLoad && !cfg.autoCalOff |-> !en && $past(calBusy))
        else $error("Early divider load");
    a_clk_framed: assert property (
        internal_vco_serial_link.serClk |-> en)
        else $error("Stray link clock");
    a_frame_len: assert property (
        $fell(en) |-> bits == 5'h10 || bits == 5'h14)
        else $error("Bad frame length");
    a_idle_quiet: assert property (
        !calBusy |-> !en) else $error("Link active while idle");
    c_cal_load: cover property (dividerLoad && !cfg.autoCalOff);
    c_cal_frame: cover property ($fell(en) && bits == 5'h14);
    c_fwd_frame: cover property ($fell(en) && bits == 5'h10);
endmodule : vco_autocal_checker

bind vco_autocal_fsm vco_autocal_checker i_vco_autocal_checker (
    .sys_clk, .reset, .cfg, .hostWr, .prescalerInt, .modulatorFrac,
    .dividerLoad, .calBusy, .internal_vco_serial_link);

// [verif/vco_model.sv]
`timescale 1ns/1ps
module vco_model
    import vco_cal_pkg::*;
(
    // Clock and reset
    input  wire logic                   sys_clk,
    input  wire logic                   reset,
    // Link from the block
    input  wire vco_cal_pkg::linkPins_t link,
    // Edge pulses to the block
    output logic                        refEdge,
    output logic                        vcoEdge,
    // Last whole word and word count
    output logic [15:0]                 lastWord,
    output int                          nWords
);
    // ----------------------------------------
    // Reference and oscillator
    // ----------------------------------------
    logic [1:0]  phase;
    logic [7:0]  acc;
    logic [4:0]  sw;
    logic [4:0]  bitCnt;
    logic [15:0] word;
    // Reference at sys_clk/3 keeps ticks under 50 MHz
    always_ff @(posedge sys_clk) begin
        phase   <= (reset || phase == 2'h2) ? 2'h0 : phase + 2'h1;
        refEdge <= !reset && phase == 2'h2;
        // Higher switch code, slower oscillator
        {vcoEdge, acc} <= reset ? 9'h000 : acc + 9'(8'hFF - {sw, 3'h0});
    end
    // First 16 bits only; cal frames pad zeros
    always_ff @(posedge sys_clk) begin
        if (reset) begin
            bitCnt <= 5'h00;
            sw     <= 5'h00;
            nWords <= 0;
        end else if (!link.serEnable) begin
            bitCnt <= 5'h00;
        end else if (link.serClk && bitCnt < 5'h10) begin
            word   <= {word[14:0], link.serData};
            bitCnt <= bitCnt + 5'h01;
            if (bitCnt == 5'h0F) begin
                lastWord <= {word[14:0], link.serData};
                nWords   <= nWords + 1;
                // Switch register only when id and index are zero
                if ({word[5:0], link.serData} == 7'h00) sw <= word[11:7];
            end
        end
    end
endmodule : vco_model

// [verif/testbench.sv]
`timescale 1ns/1ps
module testbench;
    import vco_cal_pkg::*;
    logic        sys_clk = 1'b0;
    logic        reset   = 1'b1;
    logic        refEdge, vcoEdge, dividerLoad, calBusy;
    calCfg_t     cfg     = '0;
    hostWrite_t  hostWr  = '0;
    logic [18:0] prescalerInt;
    logic [23:0] modulatorFrac;
    logic [7:0]  switchReadback, rb;
    logic [15:0] lastWord, fw;
    logic [42:0] nv;
    linkPins_t   link;
    logic [42:0] notes[$];
    int          nWords, n0, s0, t, e, len, last, base, cyc = 0;
    int          errors  = 0;
    int          n_tests = 0;
    always #4 sys_clk = ~sys_clk;
    vco_autocal_fsm i_vco_autocal_fsm (.sys_clk, .reset, .refEdge, .vcoEdge,
        .refDivRatio(14'h0001), .cfg, .hostWr, .prescalerInt, .modulatorFrac,
        .dividerLoad, .switchReadback, .calBusy,
        .internal_vco_serial_link(link));
    vco_model i_vco_model (.sys_clk, .reset, .link, .refEdge, .vcoEdge,
        .lastWord, .nWords);
    // ----------------------------------------
    // Checking and closing
    // ----------------------------------------
    task automatic check(string name, logic [42:0] ev, logic [42:0] got);
        n_tests++;
        if (got !== ev) begin
            errors++;
            $display("[FAIL] %s expected %h seen %h", name, ev, got);
        end
    endtask : check
    task automatic conclude();
        $display("Checks %0d, errors %0d", n_tests, errors);
        if (errors == 0 && n_tests > 0) begin
            $display("TB: PASS");
        end else begin
            $display("TB: FAIL");
        end
        $finish;
    endtask : conclude
    // Each load takes the oldest note; a hang ends the run
    always @(negedge sys_clk) begin
        cyc++;
        if (cyc == 40000) begin
            errors++;
            conclude();
        end
        if (dividerLoad === 1'b1) begin
            if (notes.size() == 0) check("spare load", 43'h0, 43'h1);
            else check("divider", notes.pop_front(), {prescalerInt, modulatorFrac});
        end
    end
    task automatic idle(output int n);
        n = 0;
        do begin
            @(posedge sys_clk) #1;
            n++;
        end while (calBusy !== 1'b0 && n < 9000);
    endtask : idle
    // Both strobes; mode picks the trigger
    task automatic wr(logic [18:0] iv, logic [23:0] fv);
        notes.push_back({iv, fv});
        hostWr.intValue  = iv;
        hostWr.fracValue = fv;
        hostWr.intWrite  = 1'b1;
        hostWr.fracWrite = 1'b1;
        @(posedge sys_clk) #1;
        hostWr.intWrite  = 1'b0;
        hostWr.fracWrite = 1'b0;
    endtask : wr
    task automatic fwd(logic [15:0] w);
        hostWr.fwdValue = w;
        hostWr.fwdWrite = 1'b1;
        @(posedge sys_clk) #1;
        hostWr.fwdWrite = 1'b0;
        idle(len);
    endtask : fwd
    initial begin
        s0 = $urandom(32'hD2F8);
        repeat (16) @(posedge sys_clk);
        #1 reset = 1'b0;
        @(posedge sys_clk) #1;
        // Manual: switches, then divider, per divide
        cfg.autoCalOff = 1'b1;
        for (int m = 0; m < 4; m++) begin
            cfg.clkSel   = 2'(m);
            cfg.fracMode = m[0];
            t  = 3 << (m == 3 ? 5 : 2 * m);
            fw = 16'($urandom) & 16'hFF80;
            n0 = nWords;
            fwd(fw);
            check("fwd time", 43'h1, 43'(len >= 15*t && len <= 17*t+4));
            check("fwd word", 43'(fw), 43'(lastWord));
            wr(19'($urandom), 24'($urandom));
            idle(len);
            check("no cal", 43'(n0 + 1), 43'(nWords));
        end
        // Threshold midway between switch steps
        cfg.autoCalOff = 1'b0;
        cfg.clkSel     = 2'h0;
        for (int c = 0; c < 10; c++) begin
            e = c < 4 ? c : c + 1;
            cfg.measSel  = c < 8 ? 3'(c) : 3'h7;
            cfg.waitK    = c == 9 ? 2'h1 : 2'h0;
            cfg.fracMode = c[0];
            if (c != 8) s0 = $urandom_range(15, 4);
            nv = 43'(3 * (251 - 8 * s0)) << 16;
            rb = {fw[15:13], 5'(s0)};
            n0 = nWords;
            wr(nv[42:24], nv[23:0]);
            last = len;
            idle(len);
            if (c == 0) base = len;
            e = len - base - 18 * ((1 << e) - 1);
            if (c < 8) check("window", 43'h1, 43'(e inside {[-6:6]}));
            e = len - last - 384;
            if (c == 9) check("wait", 43'h1, 43'(e inside {[-6:6]}));
            if (c < 7) continue;
            check("readback", 43'(rb), 43'(switchReadback));
            check("word", 43'({rb, fw[7:0]}), 43'(lastWord));
            check("words", 43'h7, 43'(nWords - n0));
        end
        conclude();
    end
endmodule : testbench
